// ==== design/uart_lms_defs.svh ====
// register indices, field positions, reset values and counts of the status block
// ==========================================================
`ifndef UART_LMS_DEFS_SVH
`define UART_LMS_DEFS_SVH
`define IDX_DATA	4'h0
`define IDX_IER		4'h1
`define IDX_FCR		4'h2
`define IDX_LCR		4'h3
`define IDX_MCR		4'h4
`define IDX_LSR		4'h5
`define IDX_MSR		4'h6
`define IDX_DIV		4'h8
`define LCR_PEN		3
`define LCR_EPS		4
`define LCR_STICK	5
`define LCR_SETBRK	6
`define MCR_DTR		0
`define MCR_RTS		1
`define MCR_USER_OUTPUT_1	2
`define MCR_INTERRUPT_GATE_OUTPUT	3
`define MCR_LOOP	4
`define DIV_RST		16'h000a
`define LCR_RST		8'h03
`define FIFO_DEPTH	5'h10
`endif

// ==== design/uart_lms_pkg.sv ====
// types shared by the line and modem status block
package uart_lms_pkg;
	typedef struct packed
	{
		logic		read;
		logic		write;
		logic [5:0]	address;
		logic [3:0]	byteenable;
		logic [31:0]	writedata;
	} avs_req_s;
	typedef struct packed
	{
		logic	ctsN;
		logic	dsrN;
		logic	riN;
		logic	dcdN;
	} modem_in_s;
	typedef struct packed
	{
		logic		brk;
		logic		frm;
		logic		par;
		logic [7:0]	data;
	} rx_entry_s;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKWAIT} rx_state_e;
endpackage

// ==== design/uart_line_modem_status.sv ====
// serial port status block: receive/transmit path, line status and modem status
`timescale 1ns/10ps
`include "uart_lms_defs.svh"
module uart_line_modem_status
(
	input	logic			clock,
	input	logic			rst_n,
	input	uart_lms_pkg::avs_req_s	avsReq,
	output	logic [31:0]		avsReaddata,
	output	logic			avsWaitrequest,
	input	logic			rxSerialIn,
	output	logic			txSerialOut,
	input	uart_lms_pkg::modem_in_s	modemIn,
	output	logic			terminalReadyOutN,
	output	logic			requestToSendOutN,
	output	logic			irqOut,
	output	logic			irqDriveN
);
	import uart_lms_pkg::*;

	function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lcr);
		parity_of = lcr[`LCR_STICK] ? ~lcr[`LCR_EPS] : (lcr[`LCR_EPS] ? ^d : ~^d);
	endfunction

	function automatic logic [7:0] wl_mask(input logic [1:0] l);
		wl_mask = 8'hff >> (2'd3 - l);
	endfunction

	// ==========================================================
	// synchronisers
	logic [1:0]	rxSync_r;
	modem_in_s	mSync1_r;
	modem_in_s	mSync2_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxSync_r <= 2'h3;
			mSync1_r <= 4'hf;
			mSync2_r <= 4'hf;
		end
		else
		begin
			rxSync_r <= {rxSync_r[0], rxSerialIn};
			mSync1_r <= modemIn;
			mSync2_r <= mSync1_r;
		end
	end

	// ==========================================================
	// avalon slave: one wait cycle per access
	logic		ack_r;
	logic [3:0]	ier_r;
	logic		fifoMode_r;
	logic [7:0]	lcr_r;
	logic [4:0]	mcr_r;
	logic [15:0]	div_r;
	logic [15:0]	rdVal;
	logic [7:0]	lsrVal;
	logic [7:0]	msrVal;
	logic [3:0]	idx;
	logic		rdDone;
	logic		wrDone;
	logic [7:0]	wd;
	logic		loop;
	assign idx = avsReq.address[5:2];
	assign avsWaitrequest = (avsReq.read | avsReq.write) & ~ack_r;
	assign rdDone = avsReq.read & ack_r;
	assign wrDone = avsReq.write & ack_r & avsReq.byteenable[0];
	assign wd = avsReq.writedata[7:0];
	assign loop = mcr_r[`MCR_LOOP];

	logic		fcrWr;
	logic		lsrRead;
	logic		msrRead;
	assign fcrWr = wrDone & (idx == `IDX_FCR);
	assign lsrRead = rdDone & (idx == `IDX_LSR);
	assign msrRead = rdDone & (idx == `IDX_MSR);

	logic [3:0]	rxRp_r;
	rx_entry_s	rxMem [16];
	always_comb
	begin
		rdVal = 16'h0000;
		unique case (idx)
			`IDX_DATA:	rdVal = {8'h00, rxMem[rxRp_r].data};
			`IDX_IER:	rdVal = {12'h000, ier_r};
			`IDX_FCR:	rdVal = {15'h0000, fifoMode_r};
			`IDX_LCR:	rdVal = {8'h00, lcr_r};
			`IDX_MCR:	rdVal = {11'h000, mcr_r};
			`IDX_LSR:	rdVal = {8'h00, lsrVal};
			`IDX_MSR:	rdVal = {8'h00, msrVal};
			`IDX_DIV:	rdVal = div_r;
			default:	rdVal = 16'h0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_r <= 1'b0;
			avsReaddata <= 32'h00000000;
		end
		else
		begin
			ack_r <= (avsReq.read | avsReq.write) & ~ack_r;
			if (avsReq.read & ~ack_r)
				avsReaddata <= {16'h0000, rdVal};
		end
	end

	// status registers stay read-only; writes there are dropped
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ier_r <= 4'h0;
			fifoMode_r <= 1'b0;
			lcr_r <= `LCR_RST;
			mcr_r <= 5'h00;
			div_r <= `DIV_RST;
		end
		else if (wrDone)
		begin
			unique case (idx)
				`IDX_IER:	ier_r <= wd[3:0];
				`IDX_FCR:	fifoMode_r <= wd[0];
				`IDX_LCR:	lcr_r <= wd;
				`IDX_MCR:	mcr_r <= wd[4:0];
				`IDX_DIV:
				begin
					div_r[7:0] <= wd;
					if (avsReq.byteenable[1])
						div_r[15:8] <= avsReq.writedata[15:8];
				end
				default:	ier_r <= ier_r;
			endcase
		end
	end

	// ==========================================================
	// transmitter: holding register or fifo, then shift register
	logic [7:0]	txMem [16];
	logic [3:0]	txWp_r;
	logic [3:0]	txRp_r;
	logic [4:0]	txCnt_r;
	logic [11:0]	txSh_r;
	logic [3:0]	txLeft_r;
	logic [15:0]	txTim_r;
	logic [4:0]	lim;
	logic [3:0]	wordLen;
	logic		txPush;
	logic		txLoad;
	logic		txLine;
	logic [7:0]	txD;
	logic [11:0]	txFrame;
	logic [15:0]	bitT;
	logic [15:0]	half;
	assign lim = fifoMode_r ? `FIFO_DEPTH : 5'h01;
	assign wordLen = 4'd5 + {2'b00, lcr_r[1:0]};
	assign bitT = div_r - 16'h0001;
	assign half = {1'b0, div_r[15:1]};
	assign txPush = wrDone & (idx == `IDX_DATA) & (txCnt_r != lim);
	assign txLoad = (txLeft_r == 4'h0) & (txCnt_r != 5'h00);
	assign txLine = (txLeft_r != 4'h0) ? txSh_r[0] : 1'b1;
	assign txD = txMem[txRp_r] & wl_mask(lcr_r[1:0]);

	always_comb
	begin
		txFrame = {4'hf, txD | ~wl_mask(lcr_r[1:0])};
		if (lcr_r[`LCR_PEN])
			txFrame[wordLen] = parity_of(txD, lcr_r);
	end

	always_ff @(posedge clock)
	begin
		if (txPush)
			txMem[txWp_r] <= wd;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txWp_r <= 4'h0;
			txRp_r <= 4'h0;
			txCnt_r <= 5'h00;
		end
		else if (fcrWr & (wd[2] | (wd[0] != fifoMode_r)))
		begin
			txWp_r <= 4'h0;
			txRp_r <= 4'h0;
			txCnt_r <= 5'h00;
		end
		else
		begin
			if (txPush)
				txWp_r <= txWp_r + 4'h1;
			if (txLoad)
				txRp_r <= txRp_r + 4'h1;
			txCnt_r <= txCnt_r + {4'h0, txPush} - {4'h0, txLoad};
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txSh_r <= 12'hfff;
			txLeft_r <= 4'h0;
			txTim_r <= 16'h0000;
		end
		else if (txLoad)
		begin
			txSh_r <= {txFrame[10:0], 1'b0};
			txLeft_r <= wordLen + 4'd2 + {3'h0, lcr_r[`LCR_PEN]};
			txTim_r <= bitT;
		end
		else if (txLeft_r != 4'h0)
		begin
			if (txTim_r == 16'h0000)
			begin
				txSh_r <= {1'b1, txSh_r[11:1]};
				txLeft_r <= txLeft_r - 4'h1;
				txTim_r <= bitT;
			end
			else
				txTim_r <= txTim_r - 16'h0001;
		end
	end

	// ==========================================================
	// receiver
	rx_state_e	rxSt_r;
	logic [15:0]	rxTim_r;
	logic [3:0]	rxBit_r;
	logic [7:0]	rxSh_r;
	logic		rxPar_r;
	logic		rxZero_r;
	logic		rxDone_r;
	rx_entry_s	rxEnt_r;
	rx_entry_s	rxEnt;
	logic		rxLine;
	logic		rxTick;
	logic [7:0]	rxAl;
	// loopback feeds the receiver from the shift register, not the pin
	assign rxLine = loop ? txLine : rxSync_r[1];
	assign rxTick = rxTim_r == 16'h0000;
	assign rxAl = rxSh_r >> (4'd8 - wordLen);

	always_comb
	begin
		rxEnt.brk = rxZero_r & ~rxLine;
		rxEnt.frm = ~rxLine & ~rxEnt.brk;
		rxEnt.par = lcr_r[`LCR_PEN] & ~rxEnt.brk & (rxPar_r != parity_of(rxAl, lcr_r));
		rxEnt.data = rxEnt.brk ? 8'h00 : rxAl;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxSt_r <= RX_IDLE;
			rxTim_r <= 16'h0000;
			rxBit_r <= 4'h0;
			rxSh_r <= 8'h00;
			rxPar_r <= 1'b0;
			rxZero_r <= 1'b0;
		end
		else
		begin
			if (!rxTick)
				rxTim_r <= rxTim_r - 16'h0001;
			unique case (rxSt_r)
				RX_IDLE:
					if (!rxLine)
					begin
						rxTim_r <= half;
						rxSt_r <= RX_START;
					end
				RX_START:
					if (rxTick)
					begin
						rxTim_r <= bitT;
						rxBit_r <= 4'h0;
						rxZero_r <= 1'b1;
						rxSt_r <= rxLine ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rxTick)
					begin
						rxSh_r <= {rxLine, rxSh_r[7:1]};
						rxZero_r <= rxZero_r & ~rxLine;
						rxBit_r <= rxBit_r + 4'h1;
						rxTim_r <= bitT;
						if (rxBit_r == wordLen - 4'h1)
							rxSt_r <= lcr_r[`LCR_PEN] ? RX_PAR : RX_STOP;
					end
				RX_PAR:
					if (rxTick)
					begin
						rxPar_r <= rxLine;
						rxZero_r <= rxZero_r & ~rxLine;
						rxTim_r <= bitT;
						rxSt_r <= RX_STOP;
					end
				RX_STOP:
					if (rxTick)
					begin
						if (rxEnt.brk)
						begin
							rxTim_r <= half;
							rxSt_r <= RX_BRKWAIT;
						end
						else if (!rxLine)
						begin
							// bad stop doubles as start bit; go straight to data
							rxTim_r <= bitT;
							rxBit_r <= 4'h0;
							rxZero_r <= 1'b1;
							rxSt_r <= RX_DATA;
						end
						else
							rxSt_r <= RX_IDLE;
					end
				RX_BRKWAIT:
					if (!rxLine)
						rxTim_r <= half;
					else if (rxTick)
						rxSt_r <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxDone_r <= 1'b0;
			rxEnt_r <= '0;
		end
		else
		begin
			rxDone_r <= (rxSt_r == RX_STOP) & rxTick;
			rxEnt_r <= rxEnt;
		end
	end

	// ==========================================================
	// receive buffer: depth one without fifo, sixteen with
	logic [3:0]	rxWp_r;
	logic [4:0]	rxCnt_r;
	logic [4:0]	rxErrCnt_r;
	logic		rxFull;
	logic		rxPush;
	logic		rxOvwr;
	logic		rxOvr;
	logic		rxPop;
	logic		pushErr;
	logic		headErr;
	assign rxFull = rxCnt_r == lim;
	assign rxPush = rxDone_r & ~rxFull;
	assign rxOvwr = rxDone_r & rxFull & ~fifoMode_r;
	assign rxOvr = rxDone_r & rxFull;
	assign rxPop = rdDone & (idx == `IDX_DATA) & (rxCnt_r != 5'h00);
	assign pushErr = rxEnt_r.brk | rxEnt_r.frm | rxEnt_r.par;
	assign headErr = rxMem[rxRp_r].brk | rxMem[rxRp_r].frm | rxMem[rxRp_r].par;

	always_ff @(posedge clock)
	begin
		if (rxPush)
			rxMem[rxWp_r] <= rxEnt_r;
		else if (rxOvwr)
			rxMem[rxRp_r] <= rxEnt_r;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxWp_r <= 4'h0;
			rxRp_r <= 4'h0;
			rxCnt_r <= 5'h00;
			rxErrCnt_r <= 5'h00;
		end
		else if (fcrWr & (wd[1] | (wd[0] != fifoMode_r)))
		begin
			rxWp_r <= 4'h0;
			rxRp_r <= 4'h0;
			rxCnt_r <= 5'h00;
			rxErrCnt_r <= 5'h00;
		end
		else
		begin
			if (rxPush)
				rxWp_r <= rxWp_r + 4'h1;
			if (rxPop)
				rxRp_r <= rxRp_r + 4'h1;
			rxCnt_r <= rxCnt_r + {4'h0, rxPush} - {4'h0, rxPop};
			rxErrCnt_r <= rxErrCnt_r + {4'h0, rxPush & pushErr} - {4'h0, rxPop & headErr};
		end
	end

	// ==========================================================
	// line status flags; a set in the clearing cycle wins
	logic		oe_r;
	logic		pe_r;
	logic		fe_r;
	logic		bi_r;
	logic		headNew;
	logic		headNext;
	rx_entry_s	nxtHead;
	assign headNew = (rxPush & ((rxCnt_r == 5'h00) | (rxPop & (rxCnt_r == 5'h01)))) | rxOvwr;
	assign headNext = rxPop & (rxCnt_r > 5'h01);
	assign nxtHead = rxMem[rxRp_r + 4'h1];

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oe_r <= 1'b0;
			pe_r <= 1'b0;
			fe_r <= 1'b0;
			bi_r <= 1'b0;
		end
		else
		begin
			oe_r <= (oe_r & ~lsrRead) | rxOvr;
			// errors surface as their character reaches the head
			pe_r <= (pe_r & ~lsrRead) | (headNew & rxEnt_r.par) | (headNext & nxtHead.par);
			fe_r <= (fe_r & ~lsrRead) | (headNew & rxEnt_r.frm) | (headNext & nxtHead.frm);
			bi_r <= (bi_r & ~lsrRead) | (headNew & rxEnt_r.brk) | (headNext & nxtHead.brk);
		end
	end

	logic	tx_holding_empty;
	logic	transmitter_idle;
	assign tx_holding_empty = txCnt_r == 5'h00;
	assign transmitter_idle = tx_holding_empty & (txLeft_r == 4'h0);
	assign lsrVal = {fifoMode_r & (rxErrCnt_r != 5'h00), transmitter_idle, tx_holding_empty, bi_r, fe_r, pe_r, oe_r,
		rxCnt_r != 5'h00};

	// ==========================================================
	// modem status; internal levels active high
	logic [3:0]	mAct;
	logic [3:0]	mPrev_r;
	logic [3:0]	delta_r;
	logic [3:0]	deltaSet;
	always_comb
	begin
		if (loop)
			mAct = {mcr_r[`MCR_RTS], mcr_r[`MCR_DTR], mcr_r[`MCR_USER_OUTPUT_1], mcr_r[`MCR_INTERRUPT_GATE_OUTPUT]};
		else
			mAct = ~mSync2_r;
	end
	assign deltaSet = {mAct[0] ^ mPrev_r[0], mPrev_r[1] & ~mAct[1], mAct[2] ^ mPrev_r[2],
		mAct[3] ^ mPrev_r[3]};
	assign msrVal = {mAct[0], mAct[1], mAct[2], mAct[3], delta_r};

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mPrev_r <= 4'h0;
			delta_r <= 4'h0;
		end
		else
		begin
			mPrev_r <= mAct;
			delta_r <= (delta_r & ~{4{msrRead}}) | deltaSet;
		end
	end

	// ==========================================================
	// pins and interrupt
	logic	irq;
	assign irq = (ier_r[0] & lsrVal[0]) | (ier_r[1] & tx_holding_empty)
		| (ier_r[2] & (oe_r | pe_r | fe_r | bi_r))
		| (ier_r[3] & (delta_r != 4'h0));

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txSerialOut <= 1'b1;
			terminalReadyOutN <= 1'b1;
			requestToSendOutN <= 1'b1;
			irqOut <= 1'b0;
			irqDriveN <= 1'b1;
		end
		else
		begin
			txSerialOut <= loop | (~lcr_r[`LCR_SETBRK] & txLine);
			terminalReadyOutN <= loop | ~mcr_r[`MCR_DTR];
			requestToSendOutN <= loop | ~mcr_r[`MCR_RTS];
			irqOut <= irq;
			irqDriveN <= ~mcr_r[`MCR_INTERRUPT_GATE_OUTPUT];
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_drSet; rxPush |=> lsrVal[0]; endproperty
	a_drSet: assert property (p_drSet) else $error("data ready missing after store");
	property p_drClr; rxPop & ~rxPush & (rxCnt_r == 5'h01) |=> !lsrVal[0]; endproperty
	a_drClr: assert property (p_drClr) else $error("data ready stuck after last read");
	property p_oeSet; rxOvr |=> oe_r; endproperty
	a_oeSet: assert property (p_oeSet) else $error("overrun not flagged");
	property p_oeKeep; rxOvr & fifoMode_r & ~rxPop |=> $stable(rxCnt_r); endproperty
	a_oeKeep: assert property (p_oeKeep) else $error("overrun char entered fifo");
	property p_oeClr; lsrRead & ~rxOvr |=> !oe_r; endproperty
	a_oeClr: assert property (p_oeClr) else $error("overrun not cleared by read");
	property p_resync; (rxSt_r == RX_STOP) & rxTick & rxEnt.frm |=> rxSt_r == RX_DATA ##0 rxEnt_r.frm;
	endproperty
	a_resync: assert property (p_resync) else $error("no resync after framing error");
	property p_brkZero; rxDone_r & rxEnt_r.brk |-> rxEnt_r.data == 8'h00 ##1 rxSt_r == RX_BRKWAIT;
	endproperty
	a_brkZero: assert property (p_brkZero) else $error("break char wrong");
	property p_brkWait; (rxSt_r == RX_BRKWAIT) & ~rxLine |=> rxSt_r == RX_BRKWAIT; endproperty
	a_brkWait: assert property (p_brkWait) else $error("left break wait on low line");
	property p_threClr; txPush |=> !lsrVal[5]; endproperty
	a_threClr: assert property (p_threClr) else $error("holding empty after write");
	property p_transmitter_idle; lsrVal[6] |-> (txCnt_r == 5'h00) && (txLeft_r == 4'h0) && (txLine == 1'b1);
	endproperty
	a_transmitter_idle: assert property (p_transmitter_idle) else $error("idle while data held");
	property p_bit7; !fifoMode_r |-> !lsrVal[7]; endproperty
	a_bit7: assert property (p_bit7) else $error("bit 7 set without fifo");
	property p_ring_trailing_edge_flag; mPrev_r[1] & ~mAct[1] |=> delta_r[2]; endproperty
	a_ring_trailing_edge_flag: assert property (p_ring_trailing_edge_flag) else $error("ring trailing edge lost");
	property p_dClr; msrRead & (mAct == mPrev_r) |=> delta_r == 4'h0; endproperty
	a_dClr: assert property (p_dClr) else $error("deltas not cleared by read");
	property p_mcrZero; avsReq.read & ~ack_r & (idx == `IDX_MCR) |=> avsReaddata[7:5] == 3'h0;
	endproperty
	a_mcrZero: assert property (p_mcrZero) else $error("modem control top bits nonzero");
	property p_gate; !mcr_r[`MCR_INTERRUPT_GATE_OUTPUT] |=> irqDriveN; endproperty
	a_gate: assert property (p_gate) else $error("interrupt pin driven while gated");
	property p_loopPins; loop |=> txSerialOut & terminalReadyOutN & requestToSendOutN; endproperty
	a_loopPins: assert property (p_loopPins) else $error("pins active in loopback");

	c_overrun: cover property (rxOvr & fifoMode_r);
	c_break: cover property (rxDone_r & rxEnt_r.brk);
	c_resync: cover property ((rxSt_r == RX_STOP) & rxTick & rxEnt.frm);
	c_ring_trailing_edge_flag: cover property (deltaSet[2] ##1 msrRead);
endmodule

// ==== bench/uart_lms_peer.sv ====
// serial peer and modem handshake pins facing the status block
`timescale 1ns/10ps
module uart_lms_peer
#(
	parameter int DIV_CLKS = 8
)
(
	input	wire logic			clock,
	output	logic				rxSerialIn,
	output	uart_lms_pkg::modem_in_s	modemIn,
	input	wire logic			txSerialOut
);
	import uart_lms_pkg::*;
	logic [7:0]	txByte;
	int		txCount;

	initial
	begin
		rxSerialIn = 1'b1;
		modemIn = 4'hf;
		txCount = 0;
		txByte = 8'h00;
	end

	// ==========
	// serial sender
	// lsb first; every frame ends on a high bit, so the line rests idle high
	task automatic sendBits(input logic [31:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxSerialIn <= bits[i];
			repeat (DIV_CLKS) @(posedge clock);
		end
	endtask

	task automatic sendChar(input logic [7:0] d);
		sendBits({23'h7fffff, d, 1'b0}, 10);
	endtask

	// a whole bit of idle, not only the half the receiver needs
	task automatic sendBreak();
		sendBits(32'h0, 12);
		rxSerialIn <= 1'b1;
		repeat (DIV_CLKS) @(posedge clock);
	endtask

	task automatic setModem(input logic [3:0] v);
		modemIn <= v;
	endtask

	// ==========
	// serial receiver
	// samples mid-bit, far from the edges where the design's flops move
	always @(negedge txSerialOut)
	begin
		repeat (DIV_CLKS / 2) @(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			repeat (DIV_CLKS) @(posedge clock);
			txByte[i] = txSerialOut;
		end
		txCount++;
	end
endmodule

// ==== bench/uart_line_modem_status_test.sv ====
// self-checking bench for the line and modem status block
`timescale 1ns/10ps
`include "uart_lms_defs.svh"
module uart_line_modem_status_test;
	import uart_lms_pkg::*;
	localparam int DIV = 8;
	logic		clock;
	logic		rst_n;
	avs_req_s	avsReq;
	logic [31:0]	avsReaddata;
	logic		avsWaitrequest;
	logic		rxSerialIn;
	logic		txSerialOut;
	modem_in_s	modemIn;
	logic		terminalReadyOutN;
	logic		requestToSendOutN;
	logic		irqOut;
	logic		irqDriveN;
	logic [7:0]	r;
	int		n_errors = 0;
	int		samples_checked = 0;
	int		cycles = 0;

	uart_line_modem_status dut (.clock(clock), .rst_n(rst_n), .avsReq(avsReq),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.rxSerialIn(rxSerialIn), .txSerialOut(txSerialOut), .modemIn(modemIn),
		.terminalReadyOutN(terminalReadyOutN), .requestToSendOutN(requestToSendOutN),
		.irqOut(irqOut), .irqDriveN(irqDriveN));
	uart_lms_peer #(.DIV_CLKS(DIV)) peer (.clock(clock), .rxSerialIn(rxSerialIn),
		.modemIn(modemIn), .txSerialOut(txSerialOut));

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ==========
	// verdict and checks
	task automatic give_verdict();
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// the run should need just under a tenth of this
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ==========
	// register bus
	// request held until the rising edge that sees waitrequest low; data taken there
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
		int t;
		@(posedge clock);
		avsReq <= '{read: ~wr, write: wr, address: {idx, 2'b00}, byteenable: 4'hf,
			writedata: {24'h0, wd}};
		t = 0;
		do
		begin
			@(posedge clock);
			t++;
		end
		while (avsWaitrequest !== 1'b0 && t < 50);
		if (t >= 50)
			n_errors++;
		r = avsReaddata[7:0];
		avsReq <= '0;
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rc(input logic [3:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(r, exp);
	endtask

	task automatic waitBits(input int n);
		repeat (n * DIV) @(posedge clock);
	endtask

	// ==========
	// scenarios
	task automatic tResetRegs();
		rc(`IDX_LSR, 8'h60);
		rc(`IDX_MSR, 8'h00);
		rc(4'hf, 8'h00);
		wr(`IDX_LSR, 8'hff);
		rc(`IDX_LSR, 8'h60);
		wr(`IDX_DIV, 8'(DIV));
	endtask

	task automatic tRxBasic();
		peer.sendChar(8'ha5);
		repeat (4) @(posedge clock);
		rc(`IDX_LSR, 8'h61);
		rc(`IDX_DATA, 8'ha5);
		rc(`IDX_LSR, 8'h60);
	endtask

	// bad stop bit doubles as the next start bit; second char overruns the first
	task automatic tFrameResync();
		peer.sendBits({13'h1fff, 1'b1, 8'h96, 1'b0, 8'h0f, 1'b0}, 19);
		repeat (4) @(posedge clock);
		rc(`IDX_LSR, 8'h6b);
		rc(`IDX_DATA, 8'h96);
		rc(`IDX_LSR, 8'h60);
	endtask

	task automatic tParityIrq();
		wr(`IDX_LCR, 8'h1b);
		wr(`IDX_IER, 8'h04);
		wr(`IDX_MCR, 8'h08);
		peer.sendBits({21'h1fffff, 1'b1, 1'b0, 8'h01, 1'b0}, 11);
		repeat (6) @(posedge clock);
		chk({7'h0, irqOut}, 8'h01);
		rc(`IDX_LSR, 8'h65);
		repeat (3) @(posedge clock);
		chk({7'h0, irqOut}, 8'h00);
		rc(`IDX_DATA, 8'h01);
		wr(`IDX_LCR, 8'h03);
		wr(`IDX_IER, 8'h00);
	endtask

	task automatic tFifo();
		wr(`IDX_FCR, 8'h07);
		for (int i = 0; i < 17; i++)
			peer.sendChar(8'h40 + 8'(i));
		repeat (4) @(posedge clock);
		rc(`IDX_LSR, 8'h63);
		for (int i = 0; i < 16; i++)
			rc(`IDX_DATA, 8'h40 + 8'(i));
		rc(`IDX_LSR, 8'h60);
		peer.sendBreak();
		peer.sendChar(8'h77);
		repeat (4) @(posedge clock);
		rc(`IDX_LSR, 8'hf1);
		rc(`IDX_DATA, 8'h00);
		rc(`IDX_LSR, 8'h61);
		rc(`IDX_DATA, 8'h77);
	endtask

	task automatic tTx();
		wr(`IDX_DATA, 8'h11);
		wr(`IDX_DATA, 8'h22);
		wr(`IDX_DATA, 8'h5a);
		xfer(1'b0, `IDX_LSR, 8'h00);
		chk(r & 8'h60, 8'h00);
		waitBits(40);
		rc(`IDX_LSR, 8'h60);
		chk(peer.txByte, 8'h5a);
		chk(8'(peer.txCount), 8'h03);
		wr(`IDX_FCR, 8'h00);
		wr(`IDX_DATA, 8'hc3);
		xfer(1'b0, `IDX_LSR, 8'h00);
		chk(r & 8'h40, 8'h00);
		waitBits(12);
		chk(peer.txByte, 8'hc3);
		rc(`IDX_LSR, 8'h60);
	endtask

	task automatic tModem();
		logic [23:0] pins;
		logic [47:0] modem_status_reg;
		pins = 24'h73132f;
		modem_status_reg = 48'h11327034b80b;
		for (int i = 0; i < 6; i++)
		begin
			peer.setModem(pins[23 - 4 * i -: 4]);
			repeat (8) @(posedge clock);
			rc(`IDX_MSR, modem_status_reg[47 - 8 * i -: 8]);
		end
		rc(`IDX_MSR, 8'h00);
	endtask

	// pins held active: loopback must hide them
	task automatic tLoopback();
		peer.setModem(4'h0);
		wr(`IDX_MCR, 8'hf5);
		rc(`IDX_MCR, 8'h15);
		repeat (6) @(posedge clock);
		xfer(1'b0, `IDX_MSR, 8'h00);
		chk(r & 8'hf0, 8'h60);
		chk({5'h0, txSerialOut, terminalReadyOutN, requestToSendOutN}, 8'h07);
		wr(`IDX_DATA, 8'h3c);
		waitBits(12);
		rc(`IDX_DATA, 8'h3c);
		wr(`IDX_MCR, 8'h1a);
		repeat (6) @(posedge clock);
		xfer(1'b0, `IDX_MSR, 8'h00);
		chk(r & 8'hf0, 8'h90);
		peer.setModem(4'hf);
	endtask

	task automatic tIrq();
		wr(`IDX_MCR, 8'h0b);
		wr(`IDX_IER, 8'h02);
		repeat (3) @(posedge clock);
		chk({5'h0, terminalReadyOutN, requestToSendOutN, irqDriveN}, 8'h00);
		chk({7'h0, irqOut}, 8'h01);
		wr(`IDX_IER, 8'h08);
		repeat (8) @(posedge clock);
		xfer(1'b0, `IDX_MSR, 8'h00);
		peer.setModem(4'he);
		repeat (8) @(posedge clock);
		chk({7'h0, irqOut}, 8'h01);
		xfer(1'b0, `IDX_MSR, 8'h00);
		repeat (3) @(posedge clock);
		chk({7'h0, irqOut}, 8'h00);
		wr(`IDX_MCR, 8'h00);
		repeat (3) @(posedge clock);
		chk({7'h0, irqDriveN}, 8'h01);
	endtask

	// ==========
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		avsReq = '0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		chk({5'h0, txSerialOut, irqDriveN, irqOut}, 8'h06);
		tResetRegs();
		tRxBasic();
		tFrameResync();
		tParityIrq();
		tFifo();
		tTx();
		tModem();
		tLoopback();
		tIrq();
		give_verdict();
	end
endmodule
